// file: inc/atseq_pkg.sv
package atseq_pkg;

	// Widths
	localparam int unsigned DATA_W = 24;
	localparam int unsigned ADDR_W = 10;
	localparam int unsigned QUAL_N = 4;
	localparam int unsigned LVL_N = 16;
	localparam int unsigned LVL_W = 4;
	localparam int unsigned OCC_W = 8;
	localparam int unsigned CT_W = 16;

	// Action word bit positions
	localparam int unsigned ACT_SYNC_BIT = 0;
	localparam int unsigned ACT_RUN_BIT = 1;
	localparam int unsigned ACT_STOP_BIT = 2;
	localparam int unsigned ACT_TRIG_BIT = 3;
	localparam int unsigned ACT_W = 4;

	// Qualifier response bit positions
	localparam int unsigned QRSP_STORE_BIT = 0;
	localparam int unsigned QRSP_TRIG_BIT = 1;
	localparam int unsigned QRSP_RESTART_BIT = 2;
	localparam int unsigned QRSP_W = 3;

	// Readback port codes that clear state on read
	localparam logic [3:0] PORT_CT_CLR = 4'h8;
	localparam logic [3:0] PORT_WRAP_CLR = 4'hF;

	// Reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
	localparam logic [LVL_W-1:0] LVL_RST = 4'h0;
	localparam logic [CT_W-1:0] CT_RST = 16'h0000;

	// Timer reference
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned TIMER_REF_HZ = 10_000_000;
	localparam int unsigned TIMER_DIV = CLK_HZ / TIMER_REF_HZ;
	localparam int unsigned DIV_W = 5;

	typedef enum logic {
		ATSEQ_MODE_TIMER,
		ATSEQ_MODE_COUNTER
	} atseq_mode_e;

endpackage : atseq_pkg

// file: core/atseq_word_match.sv
module atseq_word_match #(
	parameter int unsigned WIDTH = 24
) (
	input wire logic [WIDTH-1:0] data_in,
	input wire logic [WIDTH-1:0] pattern_in,
	input wire logic [WIDTH-1:0] care_in,
	input wire logic remote_match_in,
	output logic match_out
);

	// Masked compare; only counts when every slice agrees
	always_comb
	begin
		match_out = (((data_in ^ pattern_in) & care_in) == '0) && remote_match_in;
	end

endmodule : atseq_word_match

// file: core/atseq_sequencer.sv
// Function
// [R01] Four qualifier comparators with host-written patterns and per-match response bits.
// [R02] Qualifier match needs local and all expansion slices matching same cycle.
// [R03] Qualifier output enables address increment and can complete the trigger.
// [R04] Qualifier restart word forces stack level pointer to zero.
// [R05] Low external stop line inhibits address increments.
// [R06] Satisfied trigger drives shared event line low.
// [R07] Ten-bit address counter on master clock addresses acquisition RAM.
// [R08] Inhibited counter holds, so new samples overwrite one location.
// [R09] Acquisition memory writes data at current address every cycle. The code writes only on cycles with ce_in high.
// [R10] Sixteen stack words; level pointer selects the active one.
// [R11] Per-level action bits: sync, timer run, timer stop, trigger.
// [R12] Occurrence counter loads from count RAM at start and each new level.
// [R13] Occurrence counter advances only on local and all expansion stack matches.
// [R14] Occurrence expiry increments the stack level pointer.
// [R15] Initialization sets stack level pointer to zero.
// [R16] Level-advance pulse goes to expansion modules same cycle.
// [R17] Timer mode counts 10 MHz ticks once a run level is entered.
// [R18] Timer stops on stop-level completion or trigger, whichever first.
// [R19] Counter mode increments on completion of a count-step level.
// [R20] Sixteen-bit counter/timer raises wrap interrupt on each wrap.
// [R21] Host extends count by counting wrap interrupts in memory.
// [R22] Readback port 8 clears counter/timer; port F clears wrap flag.
// [R23] Increment enable is storage enable AND deasserted stop line.
module atseq_sequencer #(
	parameter int unsigned DATA_W = atseq_pkg::DATA_W,
	parameter int unsigned ADDR_W = atseq_pkg::ADDR_W,
	parameter int unsigned OCC_W = atseq_pkg::OCC_W
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic start_in,
	input wire logic [DATA_W-1:0] data_in,
	input wire logic cfg_we_in,
	input wire logic [2:0] cfg_sel_in,
	input wire logic [3:0] cfg_idx_in,
	input wire logic [DATA_W-1:0] cfg_data_in,
	input wire logic ct_mode_in,
	input wire logic [atseq_pkg::QUAL_N-1:0] exp_qual_match_in,
	input wire logic exp_stack_match_in,
	input wire logic acquisition_stop_line_n_in,
	input wire logic rd_strobe_in,
	input wire logic [3:0] rd_port_in,
	output logic [ADDR_W-1:0] acq_addr_out,
	output logic [DATA_W-1:0] acq_rd_data_out,
	input wire logic [ADDR_W-1:0] acq_rd_addr_in,
	output logic [atseq_pkg::LVL_W-1:0] level_out,
	output logic level_step_out,
	output logic sync_out,
	output logic trig_event_n_out,
	output logic [atseq_pkg::CT_W-1:0] ct_value_out,
	output logic wrap_irq_out,
	output logic [atseq_pkg::QUAL_N-1:0] qual_match_out
);

	localparam int unsigned QN = atseq_pkg::QUAL_N;
	localparam int unsigned LN = atseq_pkg::LVL_N;
	localparam int unsigned LW = atseq_pkg::LVL_W;
	localparam int unsigned CW = atseq_pkg::CT_W;
	localparam int unsigned AW = atseq_pkg::ACT_W;
	localparam int unsigned RW = atseq_pkg::QRSP_W;
	localparam logic [atseq_pkg::DIV_W-1:0] DIV_LAST =
		atseq_pkg::DIV_W'(atseq_pkg::TIMER_DIV - 1);

	// ----------------------------------------
	// Configuration memories
	// ----------------------------------------
	// cfg_sel: 0 qual pattern, 1 qual care, 2 qual response, 3 stack pattern,
	// 4 stack care, 5 action, 6 count
	logic [DATA_W-1:0] qpat_mem [QN];
	logic [DATA_W-1:0] qcare_mem [QN];
	logic [RW-1:0] qrsp_mem [QN];
	logic [DATA_W-1:0] spat_mem [LN];
	logic [DATA_W-1:0] scare_mem [LN];
	logic [AW-1:0] act_mem [LN];
	logic [OCC_W-1:0] cnt_mem [LN];
	logic [DATA_W-1:0] acq_mem [2**ADDR_W];

	function automatic logic cfg_hit(input logic [2:0] sel, input logic [2:0] want);
		cfg_hit = cfg_we_in && ce_in && (sel == want);
	endfunction : cfg_hit

	always_ff @(posedge clk_in)
	begin
		if (cfg_hit(cfg_sel_in, 3'h0) && cfg_idx_in < 4'(QN))
			qpat_mem[cfg_idx_in[1:0]] <= cfg_data_in; // [R01]
		if (cfg_hit(cfg_sel_in, 3'h1) && cfg_idx_in < 4'(QN))
			qcare_mem[cfg_idx_in[1:0]] <= cfg_data_in;
		if (cfg_hit(cfg_sel_in, 3'h2) && cfg_idx_in < 4'(QN))
			qrsp_mem[cfg_idx_in[1:0]] <= cfg_data_in[RW-1:0];
		if (cfg_hit(cfg_sel_in, 3'h3))
			spat_mem[cfg_idx_in] <= cfg_data_in; // [R10]
		if (cfg_hit(cfg_sel_in, 3'h4))
			scare_mem[cfg_idx_in] <= cfg_data_in;
		if (cfg_hit(cfg_sel_in, 3'h5))
			act_mem[cfg_idx_in] <= cfg_data_in[AW-1:0]; // [R11]
		if (cfg_hit(cfg_sel_in, 3'h6))
			cnt_mem[cfg_idx_in] <= cfg_data_in[OCC_W-1:0];
	end

	// ----------------------------------------
	// Qualifier
	// ----------------------------------------
	logic [QN-1:0] qmatch;
	logic store_en;
	logic qual_trig;
	logic restart;

	genvar gi;
	generate
		for (gi = 0; gi < QN; gi++)
		begin : g_qual
			atseq_word_match #(.WIDTH(DATA_W)) u_qm (
				.data_in(data_in),
				.pattern_in(qpat_mem[gi]),
				.care_in(qcare_mem[gi]),
				.remote_match_in(exp_qual_match_in[gi]),
				.match_out(qmatch[gi])
			); // [R02]
		end
	endgenerate

	always_comb
	begin
		store_en = 1'b0;
		qual_trig = 1'b0;
		restart = 1'b0;
		for (int i = 0; i < QN; i++)
		begin
			if (qmatch[i])
			begin
				store_en = store_en | qrsp_mem[i][atseq_pkg::QRSP_STORE_BIT]; // [R03]
				qual_trig = qual_trig | qrsp_mem[i][atseq_pkg::QRSP_TRIG_BIT];
				restart = restart | qrsp_mem[i][atseq_pkg::QRSP_RESTART_BIT]; // [R04]
			end
		end
	end

	// ----------------------------------------
	// Address counter and acquisition memory
	// ----------------------------------------
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic inc_en;

	always_comb
	begin
		inc_en = store_en && acquisition_stop_line_n_in; // [R05] [R23]
		addr_next = addr_reg;
		if (srst_in)
			addr_next = ADDR_W'(atseq_pkg::ADDR_RST);
		else if (ce_in && inc_en)
			addr_next = addr_reg + 1'b1; // [R07]
		// Held address means the next sample lands on the same word [R08]
	end

	always_ff @(posedge clk_in)
	begin
		addr_reg <= addr_next;
		if (ce_in)
			acq_mem[addr_reg] <= data_in; // [R09]
		acq_rd_data_out <= acq_mem[acq_rd_addr_in];
	end

	assign acq_addr_out = addr_reg;

	// ----------------------------------------
	// Stack recognizer and occurrence counter
	// ----------------------------------------
	logic [LW-1:0] lvl_reg, lvl_next;
	logic [OCC_W-1:0] occ_reg, occ_next;
	logic trig_reg, trig_next;
	logic sync_reg, sync_next;
	logic step_reg, step_next;
	logic smatch;
	logic lvl_done;
	logic [AW-1:0] act;

	atseq_word_match #(.WIDTH(DATA_W)) u_sm (
		.data_in(data_in),
		.pattern_in(spat_mem[lvl_reg]),
		.care_in(scare_mem[lvl_reg]),
		.remote_match_in(exp_stack_match_in),
		.match_out(smatch)
	); // [R10] [R13]

	always_comb
	begin
		act = act_mem[lvl_reg];
		// Count of zero or one both complete on the first match
		lvl_done = smatch && (occ_reg <= OCC_W'(1));
		lvl_next = lvl_reg;
		occ_next = occ_reg;
		trig_next = trig_reg;
		sync_next = sync_reg;
		step_next = 1'b0;
		if (srst_in)
		begin
			lvl_next = atseq_pkg::LVL_RST; // [R15]
			occ_next = '0;
			trig_next = 1'b0;
			sync_next = 1'b0;
		end
		else if (ce_in)
		begin
			sync_next = act[atseq_pkg::ACT_SYNC_BIT]; // [R11]
			if (start_in)
			begin
				lvl_next = atseq_pkg::LVL_RST;
				occ_next = cnt_mem[atseq_pkg::LVL_RST]; // [R12]
				trig_next = 1'b0;
			end
			else if (restart)
			begin
				lvl_next = atseq_pkg::LVL_RST; // [R04]
				occ_next = cnt_mem[atseq_pkg::LVL_RST]; // [R12]
			end
			else if (lvl_done)
			begin
				lvl_next = lvl_reg + 1'b1; // [R14]
				occ_next = cnt_mem[lvl_reg + 1'b1]; // [R12]
				step_next = 1'b1; // [R16]
				if (act[atseq_pkg::ACT_TRIG_BIT])
					trig_next = 1'b1;
			end
			else if (smatch)
				occ_next = occ_reg - 1'b1; // [R13]
			// Start outranks a qualifier trigger, so a new run never begins triggered
			if (qual_trig && !start_in)
				trig_next = 1'b1; // [R03]
		end
	end

	always_ff @(posedge clk_in)
	begin
		lvl_reg <= lvl_next;
		occ_reg <= occ_next;
		trig_reg <= trig_next;
		sync_reg <= sync_next;
		step_reg <= step_next;
	end

	assign level_out = lvl_reg;
	assign level_step_out = step_reg;
	assign sync_out = sync_reg;
	assign trig_event_n_out = ~trig_reg; // [R06]
	assign qual_match_out = qmatch;

	// ----------------------------------------
	// Counter/timer
	// ----------------------------------------
	logic [CW-1:0] ct_reg, ct_next;
	logic run_reg, run_next;
	logic wrap_reg, wrap_next;
	logic [atseq_pkg::DIV_W-1:0] div_reg, div_next;
	logic tick;
	logic ct_inc;
	logic rd_ct_clr;
	logic rd_wrap_clr;

	always_comb
	begin
		rd_ct_clr = rd_strobe_in && (rd_port_in == atseq_pkg::PORT_CT_CLR); // [R22]
		rd_wrap_clr = rd_strobe_in && (rd_port_in == atseq_pkg::PORT_WRAP_CLR); // [R22]
		tick = (div_reg == DIV_LAST);
		div_next = tick ? '0 : div_reg + 1'b1;
		run_next = run_reg;
		ct_inc = 1'b0;
		if (ct_mode_in == atseq_pkg::ATSEQ_MODE_TIMER)
		begin
			if (lvl_done && !restart && !start_in && act[atseq_pkg::ACT_STOP_BIT])
				run_next = 1'b0; // [R18]
			else if (act[atseq_pkg::ACT_RUN_BIT] && !trig_reg)
				run_next = 1'b1; // [R17]
			if (trig_reg)
				run_next = 1'b0; // [R18]
			ct_inc = run_reg && tick; // [R17]
		end
		else
		begin
			run_next = 1'b0;
			// Count-step levels use the run bit position [R19]
			ct_inc = lvl_done && !restart && !start_in && act[atseq_pkg::ACT_RUN_BIT];
		end
		ct_next = ct_reg;
		wrap_next = wrap_reg;
		if (ce_in && ct_inc)
			ct_next = ct_reg + 1'b1;
		if (rd_ct_clr)
			ct_next = atseq_pkg::CT_RST; // [R22]
		if (rd_wrap_clr)
			wrap_next = 1'b0;
		// Set wins over a clear in the same cycle
		if (ce_in && ct_inc && (ct_reg == '1))
			wrap_next = 1'b1; // [R20]
		if (!ce_in)
		begin
			div_next = div_reg;
			run_next = run_reg;
		end
		if (srst_in || (ce_in && start_in))
		begin
			ct_next = atseq_pkg::CT_RST;
			run_next = 1'b0;
			div_next = '0;
			wrap_next = srst_in ? 1'b0 : wrap_next;
		end
	end

	always_ff @(posedge clk_in)
	begin
		ct_reg <= ct_next;
		run_reg <= run_next;
		wrap_reg <= wrap_next;
		div_reg <= div_next;
	end

	assign ct_value_out = ct_reg;
	assign wrap_irq_out = wrap_reg;

endmodule : atseq_sequencer

// file: bench/atseq_checker_sva.sv
module atseq_checker #(
	parameter int unsigned ADDR_W = 10
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic start_in,
	input wire logic [atseq_pkg::QUAL_N-1:0] exp_qual_match_in,
	input wire logic exp_stack_match_in,
	input wire logic acquisition_stop_line_n_in,
	input wire logic rd_strobe_in,
	input wire logic [3:0] rd_port_in,
	input wire logic [ADDR_W-1:0] acq_addr_out,
	input wire logic [atseq_pkg::LVL_W-1:0] level_out,
	input wire logic level_step_out,
	input wire logic trig_event_n_out,
	input wire logic [atseq_pkg::CT_W-1:0] ct_value_out,
	input wire logic wrap_irq_out,
	input wire logic [atseq_pkg::QUAL_N-1:0] qual_match_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (srst_in);

	a_reset_values: assert property ($past(srst_in) |-> acq_addr_out == '0 && level_out == '0 &&
		trig_event_n_out && ct_value_out == '0 && !wrap_irq_out && !level_step_out)
		else $error("state not cleared by reset");
	a_addr_step: assert property (!$past(srst_in) && acq_addr_out != $past(acq_addr_out) |->
		acq_addr_out == $past(acq_addr_out) + 1'b1 && $past(acquisition_stop_line_n_in && ce_in))
		else $error("address moved without enable");
	a_stop_freezes: assert property (!acquisition_stop_line_n_in |=> $stable(acq_addr_out))
		else $error("address moved while stopped");
	a_level_inc: assert property (!$past(srst_in) && level_out != $past(level_out) &&
		level_out != '0 |-> level_out == $past(level_out) + 1'b1 && $past(exp_stack_match_in))
		else $error("bad level change");
	a_step_follows: assert property (!$past(srst_in) && level_out == $past(level_out) + 1'b1
		|-> ##[0:1] level_step_out)
		else $error("level advance without step pulse");
	a_start_clears: assert property (start_in && ce_in |=> level_out == '0 &&
		trig_event_n_out && ct_value_out == '0)
		else $error("start did not restart");
	a_ct_read_clear: assert property (rd_strobe_in && rd_port_in == 4'h8 |=> ct_value_out == '0)
		else $error("counter not cleared by read");
	a_wrap_read_clear: assert property (rd_strobe_in && rd_port_in == 4'hF &&
		ct_value_out != 16'hFFFF |=> !wrap_irq_out)
		else $error("wrap flag not cleared by read");
	a_wrap_sticky: assert property (wrap_irq_out && !rd_strobe_in |=> wrap_irq_out)
		else $error("wrap flag dropped");
	a_trig_sticky: assert property (!trig_event_n_out && !start_in |=> !trig_event_n_out)
		else $error("trigger released early");
	a_qual_slices: assert property ((qual_match_out & ~exp_qual_match_in) == '0)
		else $error("qualifier matched without expansion slice");

	c_step: cover property (level_step_out);
	c_trig: cover property ($fell(trig_event_n_out));
	c_hold: cover property (!acquisition_stop_line_n_in && acq_addr_out != '0);
	c_wrap: cover property ($rose(wrap_irq_out));
endmodule : atseq_checker

bind atseq_sequencer atseq_checker #(.ADDR_W(ADDR_W)) chk_u (.*);

// file: bench/atseq_far_end.sv
module atseq_far_end #(
	parameter int unsigned DELAY = 8
) (
	input wire logic clk_in,
	input wire logic trig_event_n_in,
	input wire logic veto_in,
	output logic [3:0] exp_qual_match_out,
	output logic exp_stack_match_out,
	output logic stop_line_n_out
);
	timeunit 1ns;
	timeprecision 100ps;
	int unsigned dly = 0;

	// Slices agree unless the bench forces a mismatch
	assign exp_qual_match_out = {4{~veto_in}};
	assign exp_stack_match_out = ~veto_in;
	// Delay count from trigger, then storage stopped until restart
	always @(negedge clk_in)
	begin
		if (trig_event_n_in)
			dly <= 0;
		else if (dly < DELAY)
			dly <= dly + 1;
	end
	assign stop_line_n_out = (dly < DELAY);
endmodule : atseq_far_end

// file: bench/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_in = 1'b0, srst_in = 1'b1, ce_in = 1'b1, start_in = 1'b0, ct_mode_in = 1'b1;
	logic [23:0] data_in = '0, cfg_data_in = '0, acq_rd_data_out;
	logic cfg_we_in = 1'b0, rd_strobe_in = 1'b0, veto = 1'b0;
	logic [2:0] cfg_sel_in = '0;
	logic [3:0] cfg_idx_in = '0, rd_port_in = '0, exp_qual_match_in, level_out, qual_match_out;
	logic exp_stack_match_in, acquisition_stop_line_n_in, level_step_out, sync_out;
	logic trig_event_n_out, wrap_irq_out;
	logic [9:0] acq_addr_out, acq_rd_addr_in = '0;
	logic [15:0] ct_value_out;
	int n_errors = 0, checks_done = 0, cycles = 0, wraps = 0;
	localparam logic [23:0] QPAT [4] = '{24'h0000AA, 24'h0000BB, 24'h0, 24'h0};
	localparam logic [23:0] QCARE [4] = '{24'hFFFFFF, 24'hFFFFFF, 24'h0, 24'h0};
	localparam logic [23:0] QRSP [4] = '{24'h1, 24'h4, 24'h0, 24'h0};

	atseq_sequencer dut_u (.*);
	atseq_far_end far_u (
		.clk_in(clk_in),
		.trig_event_n_in(trig_event_n_out),
		.veto_in(veto),
		.exp_qual_match_out(exp_qual_match_in),
		.exp_stack_match_out(exp_stack_match_in),
		.stop_line_n_out(acquisition_stop_line_n_in)
	);

	always #2.5 clk_in = ~clk_in;

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(negedge clk_in);
	endtask : tick

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Strobe left high so back-to-back writes never glitch it
	task automatic cfg(input logic [2:0] sel, input logic [3:0] idx, input logic [23:0] val);
		cfg_sel_in = sel;
		cfg_idx_in = idx;
		cfg_data_in = val;
		cfg_we_in = 1'b1;
		tick(1);
	endtask : cfg

	task automatic rd(input logic [3:0] p);
		rd_port_in = p;
		rd_strobe_in = 1'b1;
		tick(1);
		rd_strobe_in = 1'b0;
		tick(1);
	endtask : rd

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up

	always @(posedge clk_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 70000)
		begin
			n_errors++;
			wrap_up();
		end
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		tick(20);
		// Action memory is still unprogrammed, so sync is only defined under reset
		chk(24'({acq_addr_out, level_out, trig_event_n_out, sync_out, wrap_irq_out}), 24'h4);
		chk(24'(ct_value_out), '0);
		srst_in = 1'b0;
		tick(1);
		for (int i = 0; i < 16; i++)
		begin
			cfg(3'h3, i[3:0], 24'h000100 + 24'(i));
			cfg(3'h4, i[3:0], 24'hFFFFFF);
			cfg(3'h5, i[3:0], '0);
			cfg(3'h6, i[3:0], 24'h1);
		end
		for (int q = 0; q < 4; q++)
		begin
			cfg(3'h0, q[3:0], QPAT[q]);
			cfg(3'h1, q[3:0], QCARE[q]);
			cfg(3'h2, q[3:0], QRSP[q]);
		end
		cfg(3'h6, 4'h0, 24'h2);
		cfg(3'h5, 4'h0, 24'h2);
		cfg(3'h5, 4'h1, 24'h8);
		cfg_we_in = 1'b0;
		start_in = 1'b1;
		tick(1);
		start_in = 1'b0;
		data_in = 24'h0000AA;
		veto = 1'b1;
		tick(1);
		chk(24'(qual_match_out), '0);
		chk(24'(acq_addr_out), '0);
		veto = 1'b0;
		tick(3);
		chk(24'(qual_match_out), 24'hD);
		chk(24'(acq_addr_out), 24'h3);
		data_in = 24'h000055;
		tick(2);
		chk(24'(acq_addr_out), 24'h3);
		acq_rd_addr_in = 10'h2;
		tick(1);
		chk(acq_rd_data_out, 24'h0000AA);
		acq_rd_addr_in = 10'h3;
		tick(1);
		chk(acq_rd_data_out, 24'h000055);
		$display("storage test done");
		data_in = 24'h000100;
		veto = 1'b1;
		tick(2);
		chk(24'(level_out), '0);
		veto = 1'b0;
		tick(1);
		chk(24'(level_out), '0);
		tick(1);
		chk(24'(level_out), 24'h1);
		data_in = 24'h000101;
		tick(1);
		data_in = '0;
		tick(1);
		chk(24'({level_out, trig_event_n_out}), 24'h4);
		chk(24'(ct_value_out), 24'h1);
		tick(10);
		data_in = 24'h0000AA;
		tick(3);
		chk(24'(acq_addr_out), 24'h3);
		data_in = 24'h0000BB;
		tick(1);
		data_in = '0;
		chk(24'(level_out), '0);
		rd(4'h8);
		chk(24'(ct_value_out), '0);
		rd(4'hF);
		chk(24'(wrap_irq_out), '0);
		start_in = 1'b1;
		tick(1);
		start_in = 1'b0;
		chk(24'(trig_event_n_out), 24'h1);
		$display("sequence test done");
		cfg(3'h5, 4'h0, 24'h7);
		cfg(3'h6, 4'h0, 24'h1);
		cfg(3'h2, 4'h0, 24'h3);
		cfg_we_in = 1'b0;
		ct_mode_in = 1'b0;
		start_in = 1'b1;
		tick(1);
		start_in = 1'b0;
		tick(39);
		chk(24'({ct_value_out, sync_out}), 24'h3);
		tick(1);
		chk(24'(ct_value_out), 24'h2);
		data_in = 24'h000100;
		tick(1);
		data_in = '0;
		tick(40);
		chk(24'({ct_value_out, sync_out}), 24'h4);
		start_in = 1'b1;
		tick(1);
		start_in = 1'b0;
		tick(9);
		data_in = 24'h0000AA;
		tick(1);
		data_in = '0;
		tick(40);
		chk(24'(ct_value_out), '0);
		chk(24'(trig_event_n_out), '0);
		srst_in = 1'b1;
		tick(2);
		srst_in = 1'b0;
		tick(1);
		chk(24'({acq_addr_out, level_out, trig_event_n_out}), 24'h1);
		$display("timer test done");
		veto = 1'b1;
		ct_mode_in = 1'b1;
		for (int i = 0; i < 16; i++)
		begin
			cfg(3'h4, i[3:0], '0);
			cfg(3'h5, i[3:0], 24'h2);
		end
		cfg(3'h6, 4'h0, 24'h1);
		cfg_we_in = 1'b0;
		start_in = 1'b1;
		tick(1);
		start_in = 1'b0;
		veto = 1'b0;
		// Every level completes each cycle, so the count walks to its top
		tick(65535);
		chk(24'({ct_value_out, wrap_irq_out}), 24'h01FFFE);
		tick(1);
		chk(24'({ct_value_out, wrap_irq_out}), 24'h1);
		veto = 1'b1;
		if (wrap_irq_out === 1'b1)
			wraps++;
		rd(4'hF);
		chk(24'(wrap_irq_out), '0);
		chk(24'((wraps << 16) + ct_value_out), 24'h010000);
		$display("wrap test done");
		wrap_up();
	end
endmodule : tb_top
